// ### bench/spd_decoder_asserts.sv
`default_nettype none
module spd_decoder_asserts (
	// clock, reset, pins
	input wire logic core_clk,
	input wire logic rst,
	input wire logic prog_rst_n,
	input wire logic sck,
	input wire logic mosi,
	input wire logic miso,
	// state
	input wire logic prog_enabled,
	input wire logic busy,
	input wire logic [7:0] fuse_lo,
	input wire logic [7:0] fuse_hi,
	input wire logic [5:0] lock_bits
);
	import spd_pkg::*;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////////////////////
	// a timed write holds a while, then must end in bounded time
	sequence s_busy_run;
		busy [*8] ##[1:1000] !busy;
	endsequence
	a_reset_values: assert property (
		$fell(rst) |-> fuse_lo == SPD_FUSE_LO_RST && fuse_hi == SPD_FUSE_HI_RST && lock_bits == SPD_LOCK_RST
		&& !prog_enabled && !busy) else $error("state not at reset values");
	a_enable_in_prog: assert property (
		$rose(prog_enabled) |-> !prog_rst_n) else $error("enabled outside programming reset");
	a_prog_exit: assert property (
		prog_rst_n [*6] |-> !prog_enabled) else $error("still enabled after reset pin high");
	a_miso_on_fall: assert property (
		$changed(miso) |-> !sck) else $error("miso moved while serial clock high");
	a_busy_bounded: assert property (
		$rose(busy) |-> s_busy_run) else $error("timed write length wrong");
	a_busy_enabled: assert property (
		$rose(busy) |-> prog_enabled) else $error("write started while not enabled");
	a_fuse_gated: assert property (
		$changed({fuse_lo, fuse_hi}) |-> prog_enabled) else $error("fuse moved while not enabled");
	a_lock_gated: assert property (
		$changed(lock_bits) |-> prog_enabled) else $error("lock moved while not enabled");
endmodule // spd_decoder_asserts
bind spd_decoder spd_decoder_asserts u_chk (.core_clk(core_clk), .rst(rst), .prog_rst_n(prog_rst_n),
	.sck(sck), .mosi(mosi), .miso(miso), .prog_enabled(prog_enabled), .busy(busy),
	.fuse_lo(fuse_lo), .fuse_hi(fuse_hi), .lock_bits(lock_bits));
`default_nettype wire

// ### bench/spd_decoder_tb_top.sv
`default_nettype none
module spd_decoder_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import spd_pkg::*;
	logic core_clk, rst, prog_rst_n, prog_enabled, busy;
	wire logic sck, mosi, miso;
	logic [7:0] fuse_lo, fuse_hi;
	logic [5:0] lock_bits;
	logic [31:0] rsp;
	int fails = 0;
	int checked = 0;
	int cycles = 0;
	////////////////////////////////////////////////////////////////////////////////
	// flash page write kept long enough to be polled
	spd_decoder #(.CYC_FLASH(800), .CYC_EEPROM(20), .CYC_ERASE(20)) u_dut (.core_clk(core_clk), .rst(rst),
		.prog_rst_n(prog_rst_n), .sck(sck), .mosi(mosi), .miso(miso), .prog_enabled(prog_enabled),
		.busy(busy), .fuse_lo(fuse_lo), .fuse_hi(fuse_hi), .lock_bits(lock_bits));
	spd_prog_model u_prog (.sck(sck), .mosi(mosi), .miso(miso));
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic give_verdict();
		$display("mismatches %0d of %0d checks", fails, checked);
		if (fails == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic send(input logic [31:0] f);
		u_prog.xfer(f, rsp);
		repeat (10) @(posedge core_clk);
	endtask
	// reply shows in the frame after the request
	task automatic rd(input logic [31:0] f);
		send(f);
		send(32'h0000_0000);
	endtask
	task automatic idle();
		for (int i = 0; i < 2000 && busy !== 1'b0; i++) @(negedge core_clk);
		chk("busy", 8'h00_00, {7'h00, busy});
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_enable();
		prog_rst_n <= 1'b0;
		repeat (5) @(posedge core_clk);
		u_prog.pulses(2);
		send(32'hACA0_005A);
		chk("fuse before enable", SPD_FUSE_LO_RST, fuse_lo);
		send(32'hAC53_0000);
		chk("enable echo", SPD_B2_ENABLE, rsp[15:8]);
		chk("enabled", 8'h00_01, {7'h00, prog_enabled});
	endtask
	task automatic t_erase();
		send(32'hAC80_0000);
		idle();
		rd(32'h2000_0500);
		chk("flash erased", SPD_ERASED, rsp[7:0]);
		rd(32'hA001_2300);
		chk("eeprom erased", SPD_ERASED, rsp[7:0]);
	endtask
	task automatic t_eeprom();
		send(32'hC001_235A);
		idle();
		rd(32'hA001_2300);
		chk("eeprom byte", 8'h00_5A, rsp[7:0]);
		send(32'hC001_23A5);
		idle();
		rd(32'hA001_2300);
		chk("eeprom rewrite", 8'h00_A5, rsp[7:0]);
		rd(32'hA000_2300);
		chk("eeprom other half", SPD_ERASED, rsp[7:0]);
	endtask
	task automatic t_flash();
		send(32'h4000_0511);
		send(32'h4800_0522);
		send(32'h4C00_0000);
		rd(32'h2000_0500);
		chk("flash polling", SPD_ERASED, rsp[7:0]);
		idle();
		send(32'h4000_0533);
		send(32'h4800_0544);
		send(32'h4C00_4000);
		idle();
		rd(32'h2000_0500);
		chk("flash low", 8'h00_11, rsp[7:0]);
		rd(32'h2800_0500);
		chk("flash high", 8'h00_22, rsp[7:0]);
		rd(32'h2800_4500);
		chk("flash page one", 8'h00_44, rsp[7:0]);
	endtask
	task automatic t_fuse_ident();
		send(32'hACA0_005A);
		idle();
		chk("fuse lo port", 8'h00_5A, fuse_lo);
		send(32'hACA8_003C);
		idle();
		chk("fuse hi port", 8'h00_3C, fuse_hi);
		rd(32'h5000_0000);
		chk("fuse lo read", 8'h00_5A, rsp[7:0]);
		rd(32'h5808_0000);
		chk("fuse hi read", 8'h00_3C, rsp[7:0]);
		rd(32'h3800_0000);
		chk("calibration", SPD_CAL_RST, rsp[7:0]);
		for (int b = 0; b < 3; b++) begin
			rd({16'h3000, 6'h00, 2'(b), 8'h00});
			chk("signature", SPD_SIG_RST[23 - 8 * b -: 8], rsp[7:0]);
		end
	endtask
	// locks after the array and fuse tests, only resync follows: programmed locks may bar later access
	task automatic t_lock();
		rd(32'h5800_0000);
		chk("lock reset", {2'b00, SPD_LOCK_RST}, {2'b00, rsp[5:0]});
		send(32'hACE0_00F2);
		idle();
		chk("lock port", 8'h00_32, {2'b00, lock_bits});
		rd(32'h5800_0000);
		chk("lock read", 8'h00_32, {2'b00, rsp[5:0]});
	endtask
	// programming reset pulse mid-run: enable is lost, must be sent again
	task automatic t_resync();
		prog_rst_n <= 1'b1;
		repeat (8) @(posedge core_clk);
		chk("enable dropped", 8'h00_00, {7'h00, prog_enabled});
		prog_rst_n <= 1'b0;
		repeat (5) @(posedge core_clk);
		u_prog.pulses(2);
		send(32'hACA8_0011);
		chk("fuse hi refused", 8'h00_3C, fuse_hi);
		send(32'hAC53_0000);
		chk("resync echo", SPD_B2_ENABLE, rsp[15:8]);
		chk("enabled again", 8'h00_01, {7'h00, prog_enabled});
		rd(32'h5808_0000);
		chk("fuse hi kept", 8'h00_3C, rsp[7:0]);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// hang guard, well above the expected run length
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 60000) begin
			fails++;
			give_verdict();
		end
	end
	initial begin
		rst = 1'b1;
		prog_rst_n = 1'b1;
		repeat (6) @(posedge core_clk);
		rst <= 1'b0;
		repeat (2) @(posedge core_clk);
		t_enable();
		t_erase();
		t_eeprom();
		t_flash();
		t_fuse_ident();
		t_lock();
		t_resync();
		give_verdict();
	end
endmodule // spd_decoder_tb_top
`default_nettype wire

// ### bench/spd_prog_model.sv
`default_nettype none
module spd_prog_model (
	// link pins
	output var logic sck,
	output var logic mosi,
	input wire logic miso
);
	timeunit 1ns;
	timeprecision 100ps;
	// clock idles low between frames, it never runs free
	initial begin
		sck = 1'b0;
		mosi = 1'b0;
	end
	// bare clock pulses, used to get past link reset release
	task automatic pulses(input int n);
		#3; // keep serial edges clear of core clock edges
		repeat (n) begin
			#40 sck = 1'b1;
			#40 sck = 1'b0;
		end
	endtask
	// one frame, msb first; data set while low, reply taken at rising edge
	task automatic xfer(input logic [31:0] f, output logic [31:0] r);
		#3; // keep serial edges clear of core clock edges
		for (int i = 31; i >= 0; i--) begin
			mosi = f[i];
			#40 sck = 1'b1;
			r[i] = miso;
			#40 sck = 1'b0;
		end
		mosi = ~f[0]; // no stale bit left on a released line
	endtask
endmodule // spd_prog_model
`default_nettype wire

// ### rtl/spd_decoder.sv
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - enable frame AC 53 xx xx must precede all others while in programming reset
// - AC 100x erases flash and eeprom
// - program read returns selected byte of word a:b in byte four
// - page load stores byte at in-page word; low byte before high
// - 4C commits page buffer at page a:b
// - A0 reads eeprom at a:b during byte four
// - C0 writes byte four into eeprom at a:b
// - 58 00 returns lock bits in low six bits
// - AC 111x programs lock bits given as zero
// - AC A0 / AC A8 write low / high fuse byte
// - 50 00 / 58 08 read low / high fuse byte
// - selector bit 0 picks low byte, 1 picks high byte
// - input sampled on rising, output shifted on falling serial clock
// - byte two echoed during byte three
// - page under write reads as FF until done
// - erase fills FF; eeprom write self-erases
module spd_decoder #(
	parameter int FLASH_WORDS = 8192,
	parameter int EE_BYTES = 512,
	parameter int CYC_FLASH = spd_pkg::SPD_CYC_FLASH,
	parameter int CYC_EEPROM = spd_pkg::SPD_CYC_EEPROM,
	parameter int CYC_ERASE = spd_pkg::SPD_CYC_ERASE
) (
	// core clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// programming reset pin, active low
	input wire logic prog_rst_n,
	// serial link
	input wire logic sck,
	input wire logic mosi,
	output logic miso,
	// state
	output logic prog_enabled,
	output logic busy,
	output logic [7:0] fuse_lo,
	output logic [7:0] fuse_hi,
	output logic [5:0] lock_bits
);
	import spd_pkg::*;

	localparam int FA_W = $clog2(FLASH_WORDS);
	localparam int EA_W = $clog2(EE_BYTES);
	localparam int PG_WORDS = 1 << SPD_PG_WORD_W;

	// refuse sizes the address fields cannot reach and waits the 23-bit counter cannot hold
	if (FLASH_WORDS > 8192 || FLASH_WORDS <= PG_WORDS || EE_BYTES > 512 || EE_BYTES < 2) begin : g_bad_size
		$error("spd_decoder: unsupported size");
	end
	if (CYC_FLASH < 1 || CYC_EEPROM < 1 || CYC_ERASE < 1 || CYC_FLASH > 8388608 || CYC_EEPROM > 8388608
		|| CYC_ERASE > 8388608) begin : g_bad_wait
		$error("spd_decoder: unsupported wait length");
	end

	typedef enum logic [2:0] {
		SPD_IDLE = 3'b001,
		SPD_WAIT = 3'b010,
		SPD_DONE = 3'b100
	} spd_state_t;

	typedef enum logic [2:0] {
		SPD_JOB_FLASH = 3'b001,
		SPD_JOB_EE = 3'b010,
		SPD_JOB_ERASE = 3'b100
	} spd_job_t;

	////////////////////////////////////////////////////////////////////////////
	// reset pin sync and link-domain reset
	logic [1:0] prst_sync_reg;
	logic in_prog;
	logic [1:0] lrst_reg;
	always_ff @(posedge core_clk) begin
		if (rst)
			prst_sync_reg <= 2'b11;
		else
			prst_sync_reg <= {prst_sync_reg[0], prog_rst_n};
	end
	assign in_prog = ~prst_sync_reg[1];

	// link logic held in reset while pin is high; released by two sck edges
	always_ff @(posedge sck or posedge prog_rst_n) begin
		if (prog_rst_n)
			lrst_reg <= 2'b11;
		else
			lrst_reg <= {lrst_reg[0], 1'b0};
	end

	spd_link_if lk ();
	spd_shifter u_shift (
		.sck(sck),
		.rst_link(lrst_reg[1]),
		.mosi(mosi),
		.miso(miso),
		.lk(lk)
	);

	////////////////////////////////////////////////////////////////////////////
	// frame toggle crossing; frame word is stable when toggle is seen
	logic [2:0] tgl_sync_reg;
	logic frame_new;
	logic [31:0] fr;
	always_ff @(posedge core_clk) begin
		if (rst)
			tgl_sync_reg <= 3'b000;
		else
			tgl_sync_reg <= {tgl_sync_reg[1:0], lk.frame_tgl};
	end
	assign frame_new = (tgl_sync_reg[2] ^ tgl_sync_reg[1]) & in_prog;
	assign fr = lk.frame;

	logic [7:0] b1, b2, b3, b4;
	assign b1 = fr[31:24];
	assign b2 = fr[23:16];
	assign b3 = fr[15:8];
	assign b4 = fr[7:0];

	////////////////////////////////////////////////////////////////////////////
	// storage
	logic [15:0] flash_mem [FLASH_WORDS];
	logic [7:0] ee_mem [EE_BYTES];
	logic [15:0] page_buf [PG_WORDS];
	logic [7:0] sig_mem [3];
	logic [7:0] cal_reg;

	// fetch low or high byte of a word
	function automatic logic [7:0] pick(input logic [15:0] w, input logic hi);
		pick = hi ? w[15:8] : w[7:0];
	endfunction

	logic en_reg;
	spd_state_t state_reg;
	spd_job_t job_reg;
	logic [22:0] wait_cnt_reg;
	logic [FA_W-1:0] job_fa_reg;
	logic [EA_W-1:0] job_ea_reg;
	logic [7:0] job_data_reg;
	logic [7:0] reply_reg;

	logic [FA_W-1:0] rd_fa;
	logic [EA_W-1:0] ee_a;
	logic sel_hi;
	logic [5:0] pg_word;
	logic [FA_W-1:0] pg_base;
	assign rd_fa = FA_W'({b2[4:0], b3});
	assign ee_a = EA_W'({b2[0], b3});
	assign sel_hi = b1[SPD_SEL_BIT];
	assign pg_word = b3[SPD_PG_WORD_W-1:0];
	assign pg_base = FA_W'({b2[4:0], b3[7:6], 6'h00});

	logic is_en, is_erase, is_lockw, is_fuse_lo_w, is_fuse_hi_w, is_pg_wr, is_pg_ld, is_ee_wr;
	assign is_en = (b1 == SPD_OP_ENABLE) && (b2 == SPD_B2_ENABLE);
	assign is_erase = (b1 == SPD_OP_ENABLE) && (b2[7:5] == SPD_B2_ERASE);
	assign is_lockw = (b1 == SPD_OP_ENABLE) && (b2[7:5] == SPD_B2_LOCKW);
	assign is_fuse_lo_w = (b1 == SPD_OP_ENABLE) && (b2 == SPD_B2_FUSE_LO_W);
	assign is_fuse_hi_w = (b1 == SPD_OP_ENABLE) && (b2 == SPD_B2_FUSE_HI_W);
	assign is_pg_wr = (b1 == SPD_OP_PAGE_WR);
	assign is_pg_ld = (b1[7:4] == SPD_OP_PAGE_LD) && (b1[2:0] == 3'h0);
	assign is_ee_wr = (b1 == SPD_OP_EE_WR);

	////////////////////////////////////////////////////////////////////////////
	// enable latch: cleared by the programming reset pin
	always_ff @(posedge core_clk) begin
		if (rst || !in_prog)
			en_reg <= 1'b0;
		else if (frame_new && is_en)
			en_reg <= 1'b1;
	end

	// whether the flash page or the eeprom byte holding a read address is under write
	// the commit cycle counts too, else a read landing there sees the old word
	logic flash_busy_hit, ee_busy_hit;
	assign flash_busy_hit = (state_reg != SPD_IDLE) && (job_reg == SPD_JOB_FLASH)
		&& (rd_fa[FA_W-1:SPD_PG_WORD_W] == job_fa_reg[FA_W-1:SPD_PG_WORD_W]);
	assign ee_busy_hit = (state_reg != SPD_IDLE) && (job_reg == SPD_JOB_EE) && (ee_a == job_ea_reg);

	// answer for the next frame's byte four, computed from this frame's bytes
	// the shifter loads it at the start of byte four, long after this cycle
	always_ff @(posedge core_clk) begin
		if (rst) begin
			reply_reg <= 8'h00_00;
		end else if (frame_new) begin
			reply_reg <= 8'h00_00;
			if (en_reg) begin
				if (b1[7:4] == SPD_OP_PROG_RD && b1[2:0] == 3'h0)
					reply_reg <= flash_busy_hit ? SPD_ERASED : pick(flash_mem[rd_fa], sel_hi);
				else if (b1 == SPD_OP_EE_RD)
					reply_reg <= ee_busy_hit ? SPD_ERASED : ee_mem[ee_a];
				else if (b1 == SPD_OP_LOCK_RD && b2 == SPD_B2_ZERO)
					reply_reg <= {2'b11, lock_bits};
				else if (b1 == SPD_OP_FUSE_LO_RD && b2 == SPD_B2_ZERO)
					reply_reg <= fuse_lo;
				else if (b1 == SPD_OP_LOCK_RD && b2 == SPD_B2_FUSE_HI_RD)
					reply_reg <= fuse_hi;
				else if (b1 == SPD_OP_CAL_RD)
					reply_reg <= cal_reg;
				else if (b1 == SPD_OP_SIG_RD)
					reply_reg <= (b3[1:0] == 2'b11) ? 8'h00_00 : sig_mem[b3[1:0]];
			end
		end
	end
	assign lk.reply = reply_reg;

	////////////////////////////////////////////////////////////////////////////
	// page buffer load; a new low byte reopens the word
	always_ff @(posedge core_clk) begin
		if (rst) begin
			for (int i = 0; i < PG_WORDS; i++)
				page_buf[i] <= 16'hFFFF;
		end else if (frame_new && en_reg && is_pg_ld) begin
			if (sel_hi)
				page_buf[pg_word][15:8] <= b4;
			else
				page_buf[pg_word] <= {8'hFF, b4};
		end
	end

	// fuses, locks, constants
	always_ff @(posedge core_clk) begin
		if (rst) begin
			fuse_lo <= SPD_FUSE_LO_RST;
			fuse_hi <= SPD_FUSE_HI_RST;
			lock_bits <= SPD_LOCK_RST;
			cal_reg <= SPD_CAL_RST;
			sig_mem[0] <= SPD_SIG_RST[23:16];
			sig_mem[1] <= SPD_SIG_RST[15:8];
			sig_mem[2] <= SPD_SIG_RST[7:0];
		end else if (frame_new && en_reg && state_reg == SPD_IDLE) begin
			if (is_fuse_lo_w)
				fuse_lo <= b4;
			if (is_fuse_hi_w)
				fuse_hi <= b4;
			if (is_lockw)
				lock_bits <= lock_bits & b4[SPD_LOCK_W-1:0];
			if (is_erase)
				lock_bits <= SPD_LOCK_RST;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// self-timed write sequencer; write, erase, fuse and lock commands during a write are dropped
	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_reg <= SPD_IDLE;
			job_reg <= SPD_JOB_FLASH;
			wait_cnt_reg <= 23'h00_0000;
			job_fa_reg <= '0;
			job_ea_reg <= '0;
			job_data_reg <= 8'h00_00;
		end else begin
			case (state_reg)
				SPD_IDLE: begin
					if (frame_new && en_reg && (is_pg_wr || is_ee_wr || is_erase)) begin
						state_reg <= SPD_WAIT;
						job_fa_reg <= pg_base;
						job_ea_reg <= ee_a;
						job_data_reg <= b4;
						if (is_erase) begin
							job_reg <= SPD_JOB_ERASE;
							wait_cnt_reg <= 23'(CYC_ERASE - 1);
						end else if (is_pg_wr) begin
							job_reg <= SPD_JOB_FLASH;
							wait_cnt_reg <= 23'(CYC_FLASH - 1);
						end else begin
							job_reg <= SPD_JOB_EE;
							wait_cnt_reg <= 23'(CYC_EEPROM - 1);
						end
					end
				end
				SPD_WAIT: begin
					if (wait_cnt_reg == 23'h00_0000)
						state_reg <= SPD_DONE;
					else
						wait_cnt_reg <= wait_cnt_reg - 23'h00_0001;
				end
				SPD_DONE: state_reg <= SPD_IDLE;
				default: state_reg <= SPD_IDLE;
			endcase
		end
	end

	// array commit at end of timed write
	always_ff @(posedge core_clk) begin
		if (state_reg == SPD_DONE) begin
			case (job_reg)
				SPD_JOB_FLASH:
					for (int i = 0; i < PG_WORDS; i++)
						flash_mem[job_fa_reg + FA_W'(i)] <= page_buf[i];
				SPD_JOB_EE: ee_mem[job_ea_reg] <= job_data_reg;
				SPD_JOB_ERASE: begin
					for (int i = 0; i < FLASH_WORDS; i++)
						flash_mem[i] <= 16'hFFFF;
					for (int i = 0; i < EE_BYTES; i++)
						ee_mem[i] <= SPD_ERASED;
				end
				default: ;
			endcase
		end
	end

	// status outputs
	always_ff @(posedge core_clk) begin
		if (rst) begin
			prog_enabled <= 1'b0;
			busy <= 1'b0;
		end else begin
			prog_enabled <= en_reg;
			busy <= (state_reg != SPD_IDLE);
		end
	end
endmodule // spd_decoder
`default_nettype wire

// ### rtl/spd_link_if.sv
`default_nettype none
// frame handover between link domain and core domain
interface spd_link_if;
	logic frame_tgl; // toggles per complete four-byte frame
	logic [31:0] frame; // stable while toggle travels
	logic [7:0] reply; // byte four answer, set by core
	// echo stays in the link domain: the core only holds the previous frame's byte two
	modport link(output frame_tgl, output frame, input reply);
	modport core(input frame_tgl, input frame, output reply);
endinterface
`default_nettype wire

// ### rtl/spd_pkg.sv
`default_nettype none
package spd_pkg;
	// instruction byte patterns
	localparam logic [7:0] SPD_OP_ENABLE = 8'h00_AC;
	localparam logic [7:0] SPD_B2_ENABLE = 8'h00_53;
	localparam logic [2:0] SPD_B2_ERASE = 3'h4;
	localparam logic [2:0] SPD_B2_LOCKW = 3'h7;
	localparam logic [7:0] SPD_B2_FUSE_LO_W = 8'h00_A0;
	localparam logic [7:0] SPD_B2_FUSE_HI_W = 8'h00_A8;
	localparam logic [3:0] SPD_OP_PROG_RD = 4'h2;
	localparam logic [3:0] SPD_OP_PAGE_LD = 4'h4;
	localparam logic [7:0] SPD_OP_PAGE_WR = 8'h00_4C;
	localparam logic [7:0] SPD_OP_EE_RD = 8'h00_A0;
	localparam logic [7:0] SPD_OP_EE_WR = 8'h00_C0;
	localparam logic [7:0] SPD_OP_LOCK_RD = 8'h00_58;
	localparam logic [7:0] SPD_OP_FUSE_LO_RD = 8'h00_50;
	localparam logic [7:0] SPD_B2_FUSE_HI_RD = 8'h00_08;
	localparam logic [7:0] SPD_B2_ZERO = 8'h00_00;
	localparam logic [7:0] SPD_OP_CAL_RD = 8'h00_38;
	localparam logic [7:0] SPD_OP_SIG_RD = 8'h00_30;
	// field positions
	localparam int SPD_SEL_BIT = 3;
	localparam int SPD_PG_WORD_W = 6;
	localparam int SPD_LOCK_W = 6;
	// reset / erased values
	localparam logic [7:0] SPD_ERASED = 8'h00_FF;
	localparam logic [5:0] SPD_LOCK_RST = 6'h3F;
	localparam logic [7:0] SPD_FUSE_LO_RST = 8'h00_E1;
	localparam logic [7:0] SPD_FUSE_HI_RST = 8'h00_99;
	localparam logic [7:0] SPD_CAL_RST = 8'h00_A5; // arbitrary
	localparam logic [23:0] SPD_SIG_RST = 24'h01_0203; // arbitrary identity
	// self-timed waits
	localparam int SPD_CLK_MHZ = 125;
	localparam int SPD_T_FLASH_US = 4500;
	localparam int SPD_T_EEPROM_US = 9000;
	localparam int SPD_T_ERASE_US = 9000;
	localparam int SPD_CYC_FLASH = SPD_T_FLASH_US * SPD_CLK_MHZ;
	localparam int SPD_CYC_EEPROM = SPD_T_EEPROM_US * SPD_CLK_MHZ;
	localparam int SPD_CYC_ERASE = SPD_T_ERASE_US * SPD_CLK_MHZ;
endpackage
`default_nettype wire

// ### rtl/spd_shifter.sv
`default_nettype none
// serial shifter on the programmer's clock
module spd_shifter (
	// link pins
	input wire logic sck,
	input wire logic rst_link,
	input wire logic mosi,
	output logic miso,
	// core side
	spd_link_if.link lk
);
	logic [4:0] bit_cnt_reg;
	logic [30:0] sh_reg;
	logic [7:0] out_reg;
	logic tgl_reg;
	logic [31:0] frame_reg;

	// sample on rising edge, count bits of the frame
	always_ff @(posedge sck) begin
		if (rst_link) begin
			bit_cnt_reg <= 5'h0_0;
			sh_reg <= 31'h0000_0000;
			tgl_reg <= 1'b0;
			frame_reg <= 32'h0000_0000;
		end else begin
			bit_cnt_reg <= bit_cnt_reg + 5'h0_1;
			sh_reg <= {sh_reg[29:0], mosi};
			if (bit_cnt_reg == 5'h1_F) begin
				frame_reg <= {sh_reg, mosi};
				tgl_reg <= ~tgl_reg;
			end
		end
	end

	// shift out on falling edge: echo of byte two in byte three, reply in byte four
	always_ff @(negedge sck) begin
		if (rst_link) begin
			out_reg <= 8'h00_00;
			miso <= 1'b0;
		end else begin
			if (bit_cnt_reg == 5'h1_0)
				out_reg <= {sh_reg[6:0], 1'b0};
			else if (bit_cnt_reg == 5'h1_8)
				out_reg <= {lk.reply[6:0], 1'b0};
			else
				out_reg <= {out_reg[6:0], 1'b0};
			if (bit_cnt_reg == 5'h1_0)
				miso <= sh_reg[7];
			else if (bit_cnt_reg == 5'h1_8)
				miso <= lk.reply[7];
			else
				miso <= out_reg[7];
		end
	end

	assign lk.frame_tgl = tgl_reg;
	assign lk.frame = frame_reg;
endmodule // spd_shifter
`default_nettype wire
